// *** mmio_pkg.sv ***
// Shared constants, types and helpers of the multi-mode digital I/O bank
package mmio_pkg;

    localparam int NUM_PINS = 8;
    localparam int NUM_SERVO = 8;
    localparam int SERVO_IN_COUNT = 4;
    localparam int NUM_WAVE = 5;
    localparam int TIME_W = 24;

    // Timing: the bank runs all of its time bases on a 1 us tick
    localparam int CLK_PERIOD_NS = 40;
    localparam int TICK_PERIOD_NS = 1000;
    localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int TICK_W = 5;
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
    localparam logic [TIME_W-1:0] SERVO_FRAME_US = 24'h00_4E20;
    localparam logic [TIME_W-1:0] SERVO_MIN_US = 24'h00_03E8;
    localparam logic [TIME_W-1:0] SERVO_SPAN_US = 24'h00_03E8;
    localparam logic [TIME_W-1:0] TIME_MAX = 24'hFF_FFFF;

    // Register map, word addresses, eight words per block
    localparam logic [7:0] ADDR_PIN_BASE = 8'h00;
    localparam logic [7:0] ADDR_SERVO_BASE = 8'h10;
    localparam logic [7:0] ADDR_WAVE_CTRL = 8'h20;
    localparam logic [7:0] ADDR_WAVE_PERIOD = 8'h28;
    localparam logic [7:0] ADDR_WAVE_HIGH = 8'h30;
    localparam logic [7:0] ADDR_WAVE_COUNT = 8'h38;

    // Field positions
    localparam int FLD_MODE_LSB = 0;
    localparam int FLD_OUT_STATE = 4;
    localparam int FLD_PIN_LEVEL = 8;
    localparam int FLD_SERVO_EN = 16;
    localparam int FLD_WAVE_EN = 0;

    typedef enum logic [2:0] {
        MODE_IN = 3'h0,
        MODE_OUT = 3'h1,
        MODE_SRV_IN = 3'h2,
        MODE_SRV_OUT = 3'h3,
        MODE_WAVE_OUT = 3'h6,
        MODE_WAVE_IN = 3'h7
    } mmio_mode_t;

    typedef struct packed {
        logic out_state;
        mmio_mode_t mode;
    } mmio_pin_cfg_t;

    localparam mmio_pin_cfg_t PIN_CFG_RESET = '{out_state: 1'b0, mode: MODE_IN};

    // Which mode codes a given pin accepts
    function automatic logic mode_allowed(input logic [2:0] pin, input logic [2:0] code);
        case (code)
            MODE_IN, MODE_OUT: mode_allowed = 1'b1;
            MODE_SRV_IN: mode_allowed = (pin < 3'h4);
            MODE_SRV_OUT: mode_allowed = (pin >= 3'h4);
            MODE_WAVE_IN: mode_allowed = (pin <= 3'h4);
            MODE_WAVE_OUT: mode_allowed = (pin >= 3'h1) && (pin <= 3'h4);
            default: mode_allowed = 1'b0;
        endcase
    endfunction : mode_allowed

    // Position in us above the 1 ms minimum, clamped to the 1 ms span
    function automatic logic [TIME_W-1:0] servo_high_us(input logic [15:0] pos);
        logic [TIME_W-1:0] p;
        p = {8'h00, pos};
        servo_high_us = SERVO_MIN_US + ((p > SERVO_SPAN_US) ? SERVO_SPAN_US : p);
    endfunction : servo_high_us

    function automatic logic [15:0] servo_pos_from_us(input logic [TIME_W-1:0] us);
        logic [TIME_W-1:0] d;
        d = (us > SERVO_MIN_US) ? (us - SERVO_MIN_US) : '0;
        servo_pos_from_us = (d > SERVO_SPAN_US) ? SERVO_SPAN_US[15:0] : d[15:0];
    endfunction : servo_pos_from_us

endpackage : mmio_pkg

// *** mmio_wave_gen.sv ***
// Periodic pulse generator on the 1 us tick
`timescale 1ns/1ps
module mmio_wave_gen (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_tick,
    input wire logic i_run,
    input wire logic [mmio_pkg::TIME_W-1:0] i_period,
    input wire logic [mmio_pkg::TIME_W-1:0] i_high,
    output logic o_wave
);
    import mmio_pkg::*;

    logic [TIME_W-1:0] cnt;
    logic [TIME_W-1:0] next_cnt;
    logic live;

    assign next_cnt = cnt + 24'h00_0001;

    // Phase begins on a tick, so the first high part is as long as the later ones
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
            live <= 1'b0;
        else if (!i_run)
            live <= 1'b0;
        else if (i_tick)
            live <= 1'b1;
    end

    // Stopping clears the phase, so every start begins with a full high part
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
            cnt <= '0;
        else if (!i_run)
            cnt <= '0;
        else if (i_tick && live)
            cnt <= (next_cnt >= i_period) ? '0 : next_cnt;
    end

    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
            o_wave <= 1'b0;
        else
            o_wave <= i_run && live && (cnt < i_high);
    end

    a_zero_high_low: assert property (@(posedge i_clk) disable iff (i_reset)
        (i_run && i_high == '0) |=> !o_wave)
        else $error("wave high with zero high time");

endmodule : mmio_wave_gen

// *** mmio_edge_meter.sv ***
// High-time and transition meter for one input pin
`timescale 1ns/1ps
module mmio_edge_meter (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_tick,
    input wire logic i_run,
    input wire logic i_pin,
    output logic [mmio_pkg::TIME_W-1:0] o_high_us,
    output logic [mmio_pkg::TIME_W-1:0] o_edges
);
    import mmio_pkg::*;

    logic pin_prev;
    logic run_prev;
    logic [TIME_W-1:0] width;

    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            pin_prev <= 1'b0;
            run_prev <= 1'b0;
        end
        else
        begin
            pin_prev <= i_pin;
            run_prev <= i_run;
        end
    end

    // Count restarts on each start and holds after a stop for readback
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
            o_edges <= '0;
        else if (i_run && !run_prev)
            o_edges <= '0;
        else if (i_run && (i_pin != pin_prev) && (o_edges != TIME_MAX))
            o_edges <= o_edges + 24'h00_0001;
    end

    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
            width <= '0;
        else if (!i_run || !i_pin)
            width <= '0;
        else if (i_tick && (width != TIME_MAX))
            width <= width + 24'h00_0001;
    end

    // A pulse already high at start counts from the start, not its rise; resolution is one tick
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
            o_high_us <= '0;
        else if (i_run && run_prev && pin_prev && !i_pin)
            o_high_us <= width;
    end

    a_edge_count: assert property (@(posedge i_clk) disable iff (i_reset)
        (i_run && run_prev && (i_pin != pin_prev) && (o_edges < 24'hFF_FFF0))
        |=> o_edges == $past(o_edges) + 24'h00_0001)
        else $error("transition not counted");

    a_high_latch: assert property (@(posedge i_clk) disable iff (i_reset)
        (i_run && run_prev && pin_prev && !i_pin) |=> o_high_us == $past(width))
        else $error("high time not captured at fall");

endmodule : mmio_edge_meter

// *** mmio_bank.sv ***
// Eight-pin multi-mode digital I/O bank with register port
`timescale 1ns/1ps
module mmio_bank (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire logic [mmio_pkg::NUM_PINS-1:0] i_pin_in,
    output logic [mmio_pkg::NUM_PINS-1:0] o_pin_out,
    output logic [mmio_pkg::NUM_PINS-1:0] o_pin_oe,
    output logic [mmio_pkg::NUM_PINS-1:0] o_pull_down
);
    import mmio_pkg::*;

    function automatic logic in_block(input logic [7:0] addr, input logic [7:0] base,
                                      input int count);
        in_block = (addr[7:3] == base[7:3]) && (int'(addr[2:0]) < count);
    endfunction : in_block

    mmio_pin_cfg_t pin_cfg [NUM_PINS];
    logic [15:0] srv_pos [NUM_SERVO];
    logic [NUM_SERVO-1:0] srv_en;
    logic [NUM_WAVE-1:0] wave_en;
    logic [TIME_W-1:0] wave_period [NUM_WAVE];
    logic [TIME_W-1:0] wave_high [NUM_WAVE];
    logic [TICK_W-1:0] tick_cnt;
    logic tick;
    logic [2:0] idx;
    logic [NUM_PINS-1:0] gen_wave;
    logic [TIME_W-1:0] meas_high_us [NUM_WAVE];
    logic [TIME_W-1:0] meas_edges [NUM_WAVE];
    logic [31:0] next_rdata;

    assign idx = i_addr[2:0];

    // 1 us time base shared by every channel
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            tick_cnt <= '0;
            tick <= 1'b0;
        end
        else if (tick_cnt == TICK_LAST)
        begin
            tick_cnt <= '0;
            tick <= 1'b1;
        end
        else
        begin
            tick_cnt <= tick_cnt + 5'h01;
            tick <= 1'b0;
        end
    end

    // Pin configuration; an illegal mode code for the pin leaves the mode unchanged
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            for (int p = 0; p < NUM_PINS; p++)
                pin_cfg[p] <= PIN_CFG_RESET;
        end
        else if (i_wr && in_block(i_addr, ADDR_PIN_BASE, NUM_PINS))
        begin
            pin_cfg[idx].out_state <= i_wdata[FLD_OUT_STATE];
            if (mode_allowed(idx, i_wdata[FLD_MODE_LSB +: 3]))
                pin_cfg[idx].mode <= mmio_mode_t'(i_wdata[FLD_MODE_LSB +: 3]);
        end
    end

    // Servo channel k sits on pin k; only output channels keep a written position
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            srv_en <= '0;
            for (int k = 0; k < NUM_SERVO; k++)
                srv_pos[k] <= 16'h0000;
        end
        else if (i_wr && in_block(i_addr, ADDR_SERVO_BASE, NUM_SERVO))
        begin
            srv_en[idx] <= i_wdata[FLD_SERVO_EN];
            if (int'(idx) >= SERVO_IN_COUNT)
                srv_pos[idx] <= i_wdata[15:0];
        end
    end

    // Wave channel k sits on pin k
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            wave_en <= '0;
            for (int k = 0; k < NUM_WAVE; k++)
            begin
                wave_period[k] <= '0;
                wave_high[k] <= '0;
            end
        end
        else if (i_wr)
        begin
            if (in_block(i_addr, ADDR_WAVE_CTRL, NUM_WAVE))
                wave_en[idx] <= i_wdata[FLD_WAVE_EN];
            if (in_block(i_addr, ADDR_WAVE_PERIOD, NUM_WAVE))
                wave_period[idx] <= i_wdata[TIME_W-1:0];
            if (in_block(i_addr, ADDR_WAVE_HIGH, NUM_WAVE))
                wave_high[idx] <= i_wdata[TIME_W-1:0];
        end
    end

    // Generators: servo outputs on pins 4-7, wave outputs on pins 1-4
    assign gen_wave[0] = 1'b0;
    for (genvar p = 1; p < NUM_PINS; p++)
    begin : g_gen
        logic srv_run;
        logic wave_run;
        logic [TIME_W-1:0] period;
        logic [TIME_W-1:0] high;
        if (p >= SERVO_IN_COUNT)
        begin : g_srv
            assign srv_run = srv_en[p] && (pin_cfg[p].mode == MODE_SRV_OUT);
        end
        else
        begin : g_nosrv
            assign srv_run = 1'b0;
        end
        if (p < NUM_WAVE)
        begin : g_wave
            assign wave_run = wave_en[p] && (pin_cfg[p].mode == MODE_WAVE_OUT);
            assign period = srv_run ? SERVO_FRAME_US : wave_period[p];
            assign high = srv_run ? servo_high_us(srv_pos[p]) : wave_high[p];
        end
        else
        begin : g_nowave
            assign wave_run = 1'b0;
            assign period = SERVO_FRAME_US;
            assign high = servo_high_us(srv_pos[p]);
        end
        mmio_wave_gen u_gen (
            .i_clk(i_clk),
            .i_reset(i_reset),
            .i_tick(tick),
            .i_run(srv_run || wave_run),
            .i_period(period),
            .i_high(high),
            .o_wave(gen_wave[p])
        );
    end

    // Meters: servo inputs on pins 0-3, wave inputs on pins 0-4
    for (genvar p = 0; p < NUM_WAVE; p++)
    begin : g_meter
        logic run;
        if (p < SERVO_IN_COUNT)
        begin : g_srv
            assign run = (srv_en[p] && (pin_cfg[p].mode == MODE_SRV_IN))
                || (wave_en[p] && (pin_cfg[p].mode == MODE_WAVE_IN));
        end
        else
        begin : g_wave
            assign run = wave_en[p] && (pin_cfg[p].mode == MODE_WAVE_IN);
        end
        mmio_edge_meter u_meter (
            .i_clk(i_clk),
            .i_reset(i_reset),
            .i_tick(tick),
            .i_run(run),
            .i_pin(i_pin_in[p]),
            .o_high_us(meas_high_us[p]),
            .o_edges(meas_edges[p])
        );
    end

    // Pin drivers, registered so the pads never see decode glitches
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            o_pin_out <= '0;
            o_pin_oe <= '0;
            o_pull_down <= '1;
        end
        else
        begin
            for (int p = 0; p < NUM_PINS; p++)
            begin
                case (pin_cfg[p].mode)
                    MODE_OUT:
                    begin
                        o_pin_out[p] <= pin_cfg[p].out_state;
                        o_pin_oe[p] <= 1'b1;
                        o_pull_down[p] <= 1'b0;
                    end
                    MODE_SRV_OUT, MODE_WAVE_OUT:
                    begin
                        o_pin_out[p] <= gen_wave[p];
                        o_pin_oe[p] <= 1'b1;
                        o_pull_down[p] <= 1'b0;
                    end
                    default:
                    begin
                        o_pin_out[p] <= 1'b0;
                        o_pin_oe[p] <= 1'b0;
                        o_pull_down[p] <= 1'b1;
                    end
                endcase
            end
        end
    end

    // Read multiplexer; unmapped addresses read zero
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        if (in_block(i_addr, ADDR_PIN_BASE, NUM_PINS))
        begin
            next_rdata[FLD_MODE_LSB +: 3] = pin_cfg[idx].mode;
            next_rdata[FLD_OUT_STATE] = pin_cfg[idx].out_state;
            next_rdata[FLD_PIN_LEVEL] = i_pin_in[idx];
        end
        else if (in_block(i_addr, ADDR_SERVO_BASE, NUM_SERVO))
        begin
            next_rdata[FLD_SERVO_EN] = srv_en[idx];
            if (int'(idx) < SERVO_IN_COUNT)
                next_rdata[15:0] = servo_pos_from_us(meas_high_us[idx]);
            else
                next_rdata[15:0] = srv_pos[idx];
        end
        else if (in_block(i_addr, ADDR_WAVE_CTRL, NUM_WAVE))
            next_rdata[FLD_WAVE_EN] = wave_en[idx];
        else if (in_block(i_addr, ADDR_WAVE_PERIOD, NUM_WAVE))
            next_rdata[TIME_W-1:0] = wave_period[idx];
        else if (in_block(i_addr, ADDR_WAVE_HIGH, NUM_WAVE))
            next_rdata[TIME_W-1:0] = wave_high[idx];
        else if (in_block(i_addr, ADDR_WAVE_COUNT, NUM_WAVE))
            next_rdata[TIME_W-1:0] = meas_edges[idx];
    end

    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
            o_rdata <= 32'h0000_0000;
        else
            o_rdata <= i_rd ? next_rdata : 32'h0000_0000;
    end

    // Helper for the servo pulse width check on pin 6
    logic [16:0] hi_cnt6;
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
            hi_cnt6 <= '0;
        else if (!o_pin_out[6])
            hi_cnt6 <= '0;
        else if (hi_cnt6 != 17'h1_FFFF)
            hi_cnt6 <= hi_cnt6 + 17'h0_0001;
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    a_pin_modes_legal: assert property (
        pin_cfg[0].mode != MODE_SRV_OUT && pin_cfg[0].mode != MODE_WAVE_OUT
        && pin_cfg[7].mode != MODE_SRV_IN && pin_cfg[7].mode != MODE_WAVE_IN
        && pin_cfg[5].mode != MODE_WAVE_OUT)
        else $error("illegal mode held by a pin");

    a_out_level: assert property (
        pin_cfg[3].mode == MODE_OUT |=> o_pin_oe[3] && o_pin_out[3] == $past(pin_cfg[3].out_state))
        else $error("plain output not driving its state");

    a_input_pull: assert property (
        pin_cfg[2].mode == MODE_IN |=> !o_pin_oe[2] && o_pull_down[2])
        else $error("input pin without pull-down or still driven");

    a_level_read: assert property (
        i_rd && i_addr == 8'h05 |=> o_rdata[FLD_PIN_LEVEL] == $past(i_pin_in[5]))
        else $error("pin level read back wrong");

    a_mode_readback: assert property (
        i_rd && i_addr == 8'h01 |=> o_rdata[2:0] == $past(pin_cfg[1].mode))
        else $error("mode read back wrong");

    a_rdata_once: assert property (
        !i_rd |=> o_rdata == 32'h0000_0000)
        else $error("read data outside its cycle");

    a_servo_gate: assert property (
        (pin_cfg[5].mode == MODE_SRV_OUT && !srv_en[5])[*2] |=> !o_pin_out[5])
        else $error("disabled servo output pulsing");

    a_servo_width: assert property (
        $fell(o_pin_out[6]) && pin_cfg[6].mode == MODE_SRV_OUT && srv_en[6]
        |-> $past(hi_cnt6) >= 17'h0_61A7 && $past(hi_cnt6) <= 17'h0_C3A0)
        else $error("servo pulse outside 1-2 ms");

    a_tick_spacing: assert property (
        tick |-> ##25 tick)
        else $error("time base tick spacing wrong");

endmodule : mmio_bank

// *** mmio_far_side.sv ***
// Far-side pin model: external sources, pull-down and floating pins
`timescale 1ns/1ps
module mmio_far_side
    import mmio_pkg::*;
(
    input wire logic i_clk,
    input wire logic [NUM_PINS-1:0] i_pin_out,
    input wire logic [NUM_PINS-1:0] i_pin_oe,
    input wire logic [NUM_PINS-1:0] i_pull_down,
    output logic [NUM_PINS-1:0] o_level
);
    logic [NUM_PINS-1:0] ext_en = 8'h00;
    logic [NUM_PINS-1:0] ext_lvl = 8'h00;
    logic [NUM_PINS-1:0] noise = 8'h00;

    // A floating pin keeps toggling so a missing pull-down never reads as a clean low
    always_ff @(posedge i_clk)
    begin
        noise <= ~noise;
    end

    assign o_level = (i_pin_oe & i_pin_out) | (~i_pin_oe & ext_en & ext_lvl)
        | (~i_pin_oe & ~ext_en & ~i_pull_down & noise);

    task automatic drive(input int pin, input logic en, input logic lvl);
        @(posedge i_clk);
        ext_en[pin] <= en;
        ext_lvl[pin] <= lvl;
    endtask : drive

    // One servo-style high pulse of the given length in microseconds
    task automatic pulse(input int pin, input int us);
        drive(pin, 1'b1, 1'b1);
        repeat (us * TICK_CYCLES - 1) @(posedge i_clk);
        drive(pin, 1'b1, 1'b0);
    endtask : pulse
endmodule : mmio_far_side

// *** tb.sv ***
// Self-checking testbench of the multi-mode I/O bank
`timescale 1ns/1ps
module tb;
    import mmio_pkg::*;
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic [7:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0000_0000;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [31:0] o_rdata;
    logic [7:0] pin_lvl;
    logic [7:0] o_pin_out;
    logic [7:0] o_pin_oe;
    logic [7:0] o_pull_down;
    int error_cnt = 0;
    int n_tests = 0;
    int mode_m [8];
    logic [31:0] d;
    int h, l, p, r, wp, wh;

    mmio_bank dut (.i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pin_in(pin_lvl),
        .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe), .o_pull_down(o_pull_down));
    mmio_far_side far (.i_clk(i_clk), .i_pin_out(o_pin_out), .i_pin_oe(o_pin_oe),
        .i_pull_down(o_pull_down), .o_level(pin_lvl));

    initial
    begin
        forever #20 i_clk = ~i_clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic near(input int seen, input int exp, input int tol);
        chk(32'((seen >= exp - tol && seen <= exp + tol) ? exp : seen), 32'(exp));
    endtask : near

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= v;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 v = o_rdata;
    endtask : rd

    // Bounded wait for a rise, then length of high and following low in cycles
    task automatic measure(input int pin, output int hc, output int lc);
        int n;
        n = 0;
        hc = 0;
        lc = 0;
        while (o_pin_out[pin] !== 1'b1 && n < 200)
        begin
            @(posedge i_clk);
            n++;
        end
        while (o_pin_out[pin] === 1'b1 && hc < 60000)
        begin
            @(posedge i_clk);
            hc++;
        end
        while (o_pin_out[pin] === 1'b0 && lc < 2000)
        begin
            @(posedge i_clk);
            lc++;
        end
    endtask : measure

    function automatic logic legal(input int pin, input int code);
        case (code)
            0, 1: legal = 1'b1;
            2: legal = pin < 4;
            3: legal = pin >= 4;
            6: legal = pin >= 1 && pin <= 4;
            7: legal = pin <= 4;
            default: legal = 1'b0;
        endcase
    endfunction : legal

    task automatic results;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : results

    initial
    begin
        #(90_000 * 40);
        error_cnt++;
        $display("watchdog expired");
        results();
    end

    initial
    begin
        void'($urandom(32'hbace));
        repeat (16) @(posedge i_clk);
        i_reset <= 1'b0;
        @(posedge i_clk);
        chk(32'(o_pin_oe), 32'h0000_0000);
        chk(32'(o_pull_down), 32'h0000_00FF);
        for (int k = 0; k < 8; k++)
        begin
            rd(ADDR_PIN_BASE + 8'(k), d);
            chk(32'(d[4:0]), 32'h0000_0000);
            rd(ADDR_SERVO_BASE + 8'(k), d);
            chk(32'(d[16:0]), 32'h0000_0000);
            if (k < NUM_WAVE)
            begin
                rd(ADDR_WAVE_CTRL + 8'(k), d);
                chk(d, 32'h0000_0000);
            end
        end
        rd(8'h0F, d);
        chk(d, 32'h0000_0000);
        $display("test reset done");

        for (int k = 0; k < 8; k++)
        begin
            for (int c = 0; c < 8; c++)
            begin
                wr(8'(k), 32'h0000_0000);
                wr(8'(k), 32'(c));
                mode_m[k] = legal(k, c) ? c : 0;
                rd(8'(k), d);
                chk(32'(d[4:0]), 32'(mode_m[k]));
            end
        end
        $display("test mode table done");

        r = $urandom;
        for (int k = 0; k < 8; k++)
            wr(8'(k), 32'({r[k], 4'h1}));
        repeat (2) @(posedge i_clk);
        #1 chk(32'(o_pin_oe), 32'h0000_00FF);
        chk(32'(o_pin_out), 32'(r[7:0]));
        chk(32'(o_pull_down), 32'h0000_0000);
        r = $urandom;
        for (int k = 0; k < 8; k++)
            wr(8'(k), 32'h0000_0000);
        for (int k = 0; k < 8; k++)
            far.drive(k, 1'b1, r[k]);
        repeat (3) @(posedge i_clk);
        for (int k = 0; k < 8; k++)
        begin
            rd(8'(k), d);
            chk(32'(d[8]), 32'(r[k]));
            far.drive(k, 1'b0, 1'b0);
        end
        chk(32'(o_pull_down), 32'h0000_00FF);
        repeat (3) @(posedge i_clk);
        for (int k = 0; k < 8; k++)
        begin
            rd(8'(k), d);
            chk(32'(d[8]), 32'h0000_0000);
        end
        $display("test plain io done");

        wr(8'h00, 32'h0000_0007);
        far.drive(0, 1'b1, 1'b1);
        far.drive(0, 1'b1, 1'b0);
        repeat (4) @(posedge i_clk);
        wr(ADDR_WAVE_CTRL, 32'h0000_0001);
        repeat (4) @(posedge i_clk);
        for (int k = 0; k < 6; k++)
        begin
            far.drive(0, 1'b1, k % 2 == 0);
            repeat (3) @(posedge i_clk);
        end
        rd(ADDR_WAVE_COUNT, d);
        chk(32'(d[23:0]), 32'h0000_0006);
        wr(ADDR_WAVE_CTRL, 32'h0000_0000);
        far.drive(0, 1'b1, 1'b1);
        repeat (4) @(posedge i_clk);
        rd(ADDR_WAVE_COUNT, d);
        chk(32'(d[23:0]), 32'h0000_0006);
        far.drive(0, 1'b0, 1'b0);
        $display("test wave input done");

        wp = 4 + $urandom % 7;
        wh = 1 + $urandom % (wp - 1);
        wr(8'h02, 32'h0000_0006);
        wr(ADDR_WAVE_PERIOD + 8'h02, 32'(wp));
        wr(ADDR_WAVE_HIGH + 8'h02, 32'(wh));
        measure(2, h, l);
        chk(32'(h), 32'h0000_0000);
        wr(ADDR_WAVE_CTRL + 8'h02, 32'h0000_0001);
        measure(2, h, l);
        near(h, wh * TICK_CYCLES, TICK_CYCLES);
        near(l, (wp - wh) * TICK_CYCLES, TICK_CYCLES);
        wr(ADDR_WAVE_CTRL + 8'h02, 32'h0000_0000);
        $display("test wave output done");

        p = $urandom % 20;
        wr(8'h06, 32'h0000_0003);
        wr(ADDR_SERVO_BASE + 8'h06, 32'(p));
        measure(6, h, l);
        chk(32'(h), 32'h0000_0000);
        rd(ADDR_SERVO_BASE + 8'h06, d);
        chk(32'(d[16:0]), 32'(p));
        wr(ADDR_SERVO_BASE + 8'h06, 32'h0001_0000 | 32'(p));
        measure(6, h, l);
        near(h, (1000 + p) * TICK_CYCLES, TICK_CYCLES);
        chk(32'(l), 32'h0000_07D0);
        wr(ADDR_SERVO_BASE + 8'h06, 32'h0000_0000);
        $display("test servo output done");

        p = $urandom % 20;
        wr(8'h01, 32'h0000_0002);
        wr(ADDR_SERVO_BASE + 8'h01, 32'h0001_0000);
        repeat (4) @(posedge i_clk);
        far.pulse(1, 1000 + p);
        repeat (30) @(posedge i_clk);
        rd(ADDR_SERVO_BASE + 8'h01, d);
        near(int'(d[15:0]), p, 1);
        $display("test servo input done");
        results();
    end
endmodule : tb
